// ### core/pmcr_pkg.sv
/*
 pmcr_pkg: constants for the packet-mode connection requester.
 assumes one word clock domain shared by FIFO, requester and register port.
*/
package pmcr_pkg;
    localparam int WORD_W = 32;
    // connection request word layout
    localparam int MODE_HI = 31;
    localparam int MODE_LO = 30;
    localparam int BRK_BIT = 29;
    localparam int AOA_BIT = 28;
    localparam int CNT_HI  = 27;
    localparam int CNT_LO  = 25;
    localparam int MAP_HI  = 24;
    localparam int MAP_LO  = 0;
    localparam logic [1:0] MODE_CAMP   = 2'h0;
    localparam logic [1:0] MODE_RECAST = 2'h1;
    // word type codes, FIFO side and switch side alike
    localparam logic [1:0] TYP_IDLE = 2'h0;
    localparam logic [1:0] TYP_REQ  = 2'h1;
    localparam logic [1:0] TYP_HDR  = 2'h2;
    localparam logic [1:0] TYP_DATA = 2'h3;
    // register port
    localparam int REG_AW = 2;
    localparam logic [1:0] REG_CFG    = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam int CFG_DLY_LO  = 0;
    localparam int CFG_DLY_HI  = 3;
    localparam int CFG_D_LO    = 4;
    localparam int CFG_D_HI    = 8;
    localparam int CFG_EARLY   = 9;
    localparam logic [3:0] DLY_RESET = 4'h6;
    localparam logic [4:0] D_RESET   = 5'h0E;
    // round trip floor between request load and read strobe
    localparam logic [3:0] RTT_CYCLES = 4'h9;
    localparam int CNT_W = 10;
    localparam int RECAST_SHIFT = 2;
    typedef enum logic [3:0] {
        ST_PASS  = 4'b0001,
        ST_CAMP  = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_RECON = 4'b1000
    } pmcr_state_type;
endpackage

// ### core/pmcr_down_counter.sv
/*
 pmcr_down_counter: loadable down counter that stops at zero.
 assumes load and decrement come from logic on the same clock.
*/
`timescale 1ns/100ps
module pmcr_down_counter #(
    parameter int W = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    input  wire logic         i_dec,
    output logic              o_zero
);
    logic [W-1:0] count_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_q <= '0;
        end else if (i_load) begin
            count_q <= i_value;
        end else if (i_dec && (count_q != '0)) begin
            count_q <= count_q - W'(1);
        end
    end

    assign o_zero = (count_q == '0);
endmodule // pmcr_down_counter

// ### core/pmcr_requester.sv
/*
 pmcr_requester: transmit-side connection request sequencer, packet mode.
 assumes a first-word-fall-through FIFO on I_TX_* (word shown while valid,
 taken when O_FIFO_READ is high), switch acknowledge and delay enable and
 abort arriving asynchronously from pins, recast logic on the same clock.
*/
// Operation
// - camp-on: header before ack stops reading, repeats requests
// - ack, no delay: strobe up, header, data
// - ack with delay: wait programmed cycles first
// - delay 0..15, reset 6, zero when disabled
// - camp-on idles per request equal count field
// - at least nine cycles load to strobe
// - early request; no ack by end, normal
// - early ack: one strobe gap, one idle
// - break flag only in first request
// - camp-on requests always carry all-granted flag
// - mark up on header, down on request unless recast pending
// - early request: at most D words after request
// - recast: header stops reading, sends counted requests
// - count expired: all-granted cleared, repeat until ack
// - after that ack, header and data, delay-aware
// - recast count code: 1, then 8 doubling to 512
// - mode 00 camp-on, 01 multicast recast
`timescale 1ns/100ps
module pmcr_requester (
    input  wire logic                          I_CLK_SYS,
    input  wire logic                          I_SYS_RST,
    input  wire logic [pmcr_pkg::WORD_W-1:0]   I_TX_WORD,
    input  wire logic [1:0]                    I_TX_TYPE,
    input  wire logic                          I_TX_VALID,
    output logic                               O_FIFO_READ,
    output logic                               O_RETRANSMIT_MARK,
    output logic [pmcr_pkg::WORD_W-1:0]        O_SW_WORD,
    output logic [1:0]                         O_SW_TYPE,
    input  wire logic                          I_SW_ACK,
    input  wire logic                          I_POST_ACK_DELAY_ENABLE,
    input  wire logic                          I_ABORT,
    input  wire logic                          I_RECAST_PENDING,
    input  wire logic [pmcr_pkg::REG_AW-1:0]   I_REG_ADDR,
    input  wire logic [pmcr_pkg::WORD_W-1:0]   I_REG_WDATA,
    input  wire logic                          I_REG_WR,
    input  wire logic                          I_REG_RD,
    output logic [pmcr_pkg::WORD_W-1:0]        O_REG_RDATA
);
    import pmcr_pkg::*;

    pmcr_state_type state_q;
    logic              ack_s1_q;
    logic              ack_s2_q;
    logic              dly_s1_q;
    logic              dly_s2_q;
    logic              abt_s1_q;
    logic              abt_s2_q;
    logic              abt_prev_q;
    logic [3:0]        cfg_dly_q;
    logic [4:0]        cfg_d_q;
    logic              cfg_early_q;
    logic [WORD_W-1:0] rdata_q;
    logic [WORD_W-1:0] req_q;
    logic [WORD_W-1:0] hdr_q;
    logic              req_seen_q;
    logic              ack_got_q;
    logic              discard_q;
    logic              mark_q;
    logic [3:0]        rtt_q;
    logic [4:0]        after_q;
    logic [2:0]        gap_q;
    logic [WORD_W-1:0] out_word_q;
    logic [1:0]        out_type_q;

    logic              take;
    logic              ack_new;
    logic              abt_rise;
    logic              rtt_done;
    logic              dly_zero;
    logic              left_zero;
    logic              camp_send;
    logic              recast_mode;
    logic [3:0]        eff_dly;
    logic [4:0]        eff_d;
    logic [CNT_W-1:0]  recast_num;
    logic [2:0]        ct_field;
    logic [WORD_W-1:0] camp_word;

    // pins from outside the word clock: two flops before any use
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            dly_s1_q <= 1'b0;
            dly_s2_q <= 1'b0;
            abt_s1_q <= 1'b0;
            abt_s2_q <= 1'b0;
            abt_prev_q <= 1'b0;
        end else begin
            ack_s1_q <= I_SW_ACK;
            ack_s2_q <= ack_s1_q;
            dly_s1_q <= I_POST_ACK_DELAY_ENABLE;
            dly_s2_q <= dly_s1_q;
            abt_s1_q <= I_ABORT;
            abt_s2_q <= abt_s1_q;
            abt_prev_q <= abt_s2_q;
        end
    end

    // configuration register
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            cfg_dly_q <= DLY_RESET;
            cfg_d_q <= D_RESET;
            cfg_early_q <= 1'b0;
        end else if (I_REG_WR && (I_REG_ADDR == REG_CFG)) begin
            cfg_dly_q <= I_REG_WDATA[CFG_DLY_HI:CFG_DLY_LO];
            cfg_d_q <= I_REG_WDATA[CFG_D_HI:CFG_D_LO];
            cfg_early_q <= I_REG_WDATA[CFG_EARLY];
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            rdata_q <= '0;
        end else if (I_REG_RD && (I_REG_ADDR == REG_CFG)) begin
            rdata_q <= '0;
            rdata_q[CFG_DLY_HI:CFG_DLY_LO] <= cfg_dly_q;
            rdata_q[CFG_D_HI:CFG_D_LO] <= cfg_d_q;
            rdata_q[CFG_EARLY] <= cfg_early_q;
        end else if (I_REG_RD && (I_REG_ADDR == REG_STATUS)) begin
            rdata_q <= {{(WORD_W-7){1'b0}}, state_q, mark_q, ack_got_q, req_seen_q};
        end else begin
            rdata_q <= '0;
        end
    end

    assign O_REG_RDATA = rdata_q;

    assign recast_mode = (req_q[MODE_HI:MODE_LO] == MODE_RECAST);
    assign ct_field = req_q[CNT_HI:CNT_LO];
    assign eff_dly = dly_s2_q ? cfg_dly_q : 4'h0;
    // without early arbitration only the header may follow a request
    assign eff_d = cfg_early_q ? cfg_d_q : 5'h00;
    assign rtt_done = (rtt_q == RTT_CYCLES);
    // abort window swallows any acknowledge still in flight
    assign ack_new = ack_s2_q && req_seen_q && !ack_got_q && !abt_s2_q;
    assign abt_rise = abt_s2_q && !abt_prev_q;

    // recast request count: code 0 gives one, else eight doubling
    always_comb begin
        recast_num = '0;
        if (ct_field == 3'h0) begin
            recast_num = CNT_W'(1);
        end else begin
            // four-bit sum: codes 6 and 7 would wrap a three-bit shift amount
            recast_num = CNT_W'(1) << (4'(ct_field) + 4'(RECAST_SHIFT));
        end
    end

    // repeated request: break cleared, all-granted per mode and count
    always_comb begin
        camp_word = req_q;
        camp_word[BRK_BIT] = 1'b0;
        if (recast_mode) begin
            camp_word[AOA_BIT] = !left_zero;
        end else begin
            camp_word[AOA_BIT] = 1'b1;
        end
    end

    assign camp_send = (state_q == ST_CAMP) && !ack_got_q && (gap_q == 3'h0);

    // read strobe: a request that outran D words lets only the header in
    always_comb begin
        O_FIFO_READ = 1'b0;
        if ((state_q == ST_PASS) && I_TX_VALID && !abt_rise) begin
            if (req_seen_q && !ack_got_q && (after_q >= eff_d)) begin
                O_FIFO_READ = (I_TX_TYPE == TYP_HDR);
            end else begin
                O_FIFO_READ = 1'b1;
            end
        end
    end

    assign take = O_FIFO_READ;

    pmcr_down_counter #(
        .W(4)
    ) u_post_ack_delay (
        .i_clk  (I_CLK_SYS),
        .i_rst  (I_SYS_RST),
        .i_load (ack_new),
        .i_value(eff_dly),
        .i_dec  (1'b1),
        .o_zero (dly_zero)
    );

    pmcr_down_counter #(
        .W(CNT_W)
    ) u_recast_left (
        .i_clk  (I_CLK_SYS),
        .i_rst  (I_SYS_RST),
        .i_load (take && (I_TX_TYPE == TYP_HDR)),
        .i_value(recast_num),
        .i_dec  (camp_send && recast_mode),
        .o_zero (left_zero)
    );

    // round trip floor and words sent after a request
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            rtt_q <= '0;
            after_q <= '0;
        end else if (take && (I_TX_TYPE == TYP_REQ)) begin
            rtt_q <= '0;
            after_q <= '0;
        end else begin
            if (!rtt_done) begin
                rtt_q <= rtt_q + 4'h1;
            end
            if (take && (I_TX_TYPE == TYP_DATA) && (after_q != 5'h1F)) begin
                after_q <= after_q + 5'h01;
            end
        end
    end

    // acknowledge bookkeeping
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            ack_got_q <= 1'b0;
        end else if (abt_rise || (take && (I_TX_TYPE == TYP_REQ))) begin
            ack_got_q <= 1'b0;
        end else if (ack_new) begin
            ack_got_q <= 1'b1;
        end
    end

    // retransmit mark; pending recast keeps it up over new requests
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            mark_q <= 1'b0;
        end else if (abt_rise) begin
            mark_q <= 1'b0;
        end else if (take && (I_TX_TYPE == TYP_HDR) && !discard_q) begin
            mark_q <= 1'b1;
        end else if (take && (I_TX_TYPE == TYP_REQ) && !I_RECAST_PENDING) begin
            mark_q <= 1'b0;
        end
    end

    assign O_RETRANSMIT_MARK = mark_q;

    // camp gap counter: idles between repeated requests
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            gap_q <= '0;
        end else if (state_q != ST_CAMP) begin
            gap_q <= '0;
        end else if (camp_send) begin
            gap_q <= recast_mode ? 3'h0 : ct_field;
        end else if (gap_q != 3'h0) begin
            gap_q <= gap_q - 3'h1;
        end
    end

    // sequencer, request latch and the switch-side word register
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            state_q <= ST_PASS;
            req_q <= '0;
            hdr_q <= '0;
            req_seen_q <= 1'b0;
            discard_q <= 1'b0;
            out_word_q <= '0;
            out_type_q <= TYP_IDLE;
        end else if (abt_rise) begin
            // one empty request releases whatever the switch holds
            out_word_q <= req_q;
            out_word_q[MAP_HI:MAP_LO] <= '0;
            out_word_q[BRK_BIT] <= 1'b0;
            out_word_q[AOA_BIT] <= 1'b1;
            out_type_q <= TYP_REQ;
            req_seen_q <= 1'b0;
            discard_q <= 1'b1;
            state_q <= ST_PASS;
        end else begin
            out_word_q <= '0;
            out_type_q <= TYP_IDLE;
            case (state_q)
                ST_PASS: begin
                    if (take && (I_TX_TYPE == TYP_REQ)) begin
                        req_q <= I_TX_WORD;
                        req_seen_q <= 1'b1;
                        discard_q <= 1'b0;
                        out_word_q <= I_TX_WORD;
                        out_word_q[BRK_BIT] <= 1'b1;
                        out_word_q[AOA_BIT] <= 1'b1;
                        out_type_q <= TYP_REQ;
                    end else if (take && (I_TX_TYPE == TYP_HDR) && !discard_q) begin
                        if (!req_seen_q) begin
                            out_word_q <= I_TX_WORD;
                            out_type_q <= TYP_HDR;
                        end else if (ack_got_q) begin
                            // early grant: hold header, let switch reconfigure
                            hdr_q <= I_TX_WORD;
                            if (dly_zero && rtt_done) begin
                                state_q <= ST_RECON;
                            end else begin
                                state_q <= ST_WAIT;
                            end
                        end else begin
                            hdr_q <= I_TX_WORD;
                            state_q <= ST_CAMP;
                        end
                    end else if (take && (I_TX_TYPE == TYP_DATA) && !discard_q) begin
                        out_word_q <= I_TX_WORD;
                        out_type_q <= TYP_DATA;
                    end
                end
                ST_CAMP: begin
                    if (ack_got_q) begin
                        if (dly_zero && rtt_done) begin
                            out_word_q <= hdr_q;
                            out_type_q <= TYP_HDR;
                            req_seen_q <= 1'b0;
                            state_q <= ST_PASS;
                        end
                    end else if (camp_send) begin
                        out_word_q <= camp_word;
                        out_type_q <= TYP_REQ;
                    end
                end
                ST_WAIT: begin
                    if (dly_zero && rtt_done) begin
                        state_q <= ST_RECON;
                    end
                end
                ST_RECON: begin
                    // strobe was low for this one cycle, idle already sent
                    out_word_q <= hdr_q;
                    out_type_q <= TYP_HDR;
                    req_seen_q <= 1'b0;
                    state_q <= ST_PASS;
                end
                default: begin
                    state_q <= ST_PASS;
                end
            endcase
        end
    end

    assign O_SW_WORD = out_word_q;
    assign O_SW_TYPE = out_type_q;
endmodule // pmcr_requester

// ### verification/pmcr_requester_properties.sv
/*
 pmcr_requester_checker: port-level properties of the requester, bound in.
 assumes one word clock, synchronous active-high reset, abort only with count 0.
*/
`timescale 1ns/100ps
module pmcr_requester_checker (
    input wire logic                        I_CLK_SYS,
    input wire logic                        I_SYS_RST,
    input wire logic [1:0]                  I_TX_TYPE,
    input wire logic                        I_TX_VALID,
    input wire logic                        O_FIFO_READ,
    input wire logic                        O_RETRANSMIT_MARK,
    input wire logic [pmcr_pkg::WORD_W-1:0] O_SW_WORD,
    input wire logic [1:0]                  O_SW_TYPE
);
    import pmcr_pkg::*;
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_SYS_RST);
    logic       take_req, take_hdr, out_req, out_brk, out_aoa, out_camp;
    logic [4:0] since_q;
    logic [2:0] idle_q;
    logic [9:0] run_q, run_exp;
    assign take_req = O_FIFO_READ && I_TX_VALID && I_TX_TYPE == TYP_REQ;
    assign take_hdr = O_FIFO_READ && I_TX_VALID && I_TX_TYPE == TYP_HDR;
    assign out_req  = O_SW_TYPE == TYP_REQ;
    assign out_brk  = O_SW_WORD[BRK_BIT];
    assign out_aoa  = O_SW_WORD[AOA_BIT];
    assign out_camp = O_SW_WORD[MODE_HI:MODE_LO] == MODE_CAMP;
    // 8 << (code - 1) written as 4 << code
    assign run_exp  = (O_SW_WORD[CNT_HI:CNT_LO] == 3'h0) ? 10'h001
                    : (10'h004 << O_SW_WORD[CNT_HI:CNT_LO]);
    // saturates so a header with no request behind it stays unconstrained
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) since_q <= 5'h1F;
        else if (take_req) since_q <= 5'h00;
        else if (since_q != 5'h1F) since_q <= since_q + 5'h01;
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) idle_q <= 3'h0;
        else if (out_req && !out_brk && out_camp) idle_q <= O_SW_WORD[CNT_HI:CNT_LO];
        else if (idle_q != 3'h0) idle_q <= idle_q - 3'h1;
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST || (out_req && out_brk)) run_q <= 10'h000;
        else if (out_req && out_aoa && !out_camp) run_q <= run_q + 10'h001;
    end
    a_break_first: assert property (out_req |-> out_brk == $past(take_req))
        else $error("break flag not only in first request");
    a_camp_all_granted: assert property (out_req && out_camp |-> out_aoa)
        else $error("camp request without all-granted flag");
    a_camp_idle_gap: assert property (idle_q != 3'h0 |-> !out_req)
        else $error("camp request before its idle words ran out");
    a_header_stall: assert property (take_hdr && since_q < 5'h08 |=> !O_FIFO_READ)
        else $error("read strobe kept up after early header");
    a_mark_rise: assert property ($rose(O_RETRANSMIT_MARK) |-> $past(take_hdr))
        else $error("mark rose without a header taken");
    a_mark_fall: assert property ($fell(O_RETRANSMIT_MARK) |-> out_req)
        else $error("mark fell without a new request");
    a_round_trip: assert property (O_SW_TYPE == TYP_HDR |-> since_q >= 5'h08)
        else $error("header sent too soon after request");
    a_recast_count: assert property (out_req && !out_camp && !out_aoa && !out_brk
        |-> run_q == run_exp)
        else $error("recast request count wrong");
    c_single_grant: cover property (out_req && !out_camp && !out_aoa);
    c_held_header: cover property (O_SW_TYPE == TYP_HDR && O_RETRANSMIT_MARK);
    c_long_idle: cover property (idle_q == 3'h7);
endmodule // pmcr_requester_checker

bind pmcr_requester pmcr_requester_checker i_chk (
    .I_CLK_SYS, .I_SYS_RST, .I_TX_TYPE, .I_TX_VALID,
    .O_FIFO_READ, .O_RETRANSMIT_MARK, .O_SW_WORD, .O_SW_TYPE
);

// ### verification/pmcr_switch_model.sv
/*
 pmcr_switch_model: crosspoint arbiter as one port sees it; acks requests.
 assumes request words arrive registered on the word clock.
*/
`timescale 1ns/100ps
module pmcr_switch_model (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic [pmcr_pkg::WORD_W-1:0] i_word,
    input  wire logic [1:0]                  i_type,
    input  wire logic [24:0]                 i_avail,
    output logic                             o_ack
);
    import pmcr_pkg::*;
    logic [24:0] granted_q, map, gnt;
    always_comb begin
        map = i_word[MAP_HI:MAP_LO];
        // camp-on words are judged alone; multicast keeps what it won
        gnt = ((i_word[MODE_HI:MODE_LO] == MODE_CAMP || i_word[BRK_BIT]) ? 25'h0
              : granted_q) | (map & i_avail);
    end
    // ack is a level that each new request re-decides
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            granted_q <= 25'h0;
            o_ack     <= 1'b0;
        end else if (i_type == TYP_REQ) begin
            granted_q <= gnt;
            o_ack     <= (map != 25'h0) && (i_word[AOA_BIT] ? gnt == map : gnt != 25'h0);
        end else if (i_type == TYP_HDR) begin
            // header ends the grant, so the next request never sees a stale ack
            o_ack     <= 1'b0;
        end
    end
endmodule // pmcr_switch_model

// ### verification/tb_top.sv
/*
 tb_top: requester bench, queue as first-word-fall-through FIFO, switch model.
 assumes the checker is bound to the requester by its own file.
*/
`timescale 1ns/100ps
module tb_top;
    import pmcr_pkg::*;
    logic        clk, rst, tx_valid, rd, wr, dly_en, abort_in, pend, fifo_rd, mark, ack;
    logic        hdr_idle;
    logic [1:0]  tx_type, sw_type, addr, cur_mode, sw_type_prev;
    logic [31:0] tx_word, sw_word, wdata, rdata, v;
    logic [24:0] avail;
    logic [33:0] q[$];
    int          err_total = 0, num_checks = 0, cyc = 0, gap_bad = 0;
    int          t_ack, t_hdr, t_req, nrun, naoa0, lat0, lat, ndat, cur_ct;

    pmcr_requester i_dut (
        .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_TX_WORD(tx_word), .I_TX_TYPE(tx_type),
        .I_TX_VALID(tx_valid), .O_FIFO_READ(fifo_rd), .O_RETRANSMIT_MARK(mark),
        .O_SW_WORD(sw_word), .O_SW_TYPE(sw_type), .I_SW_ACK(ack),
        .I_POST_ACK_DELAY_ENABLE(dly_en), .I_ABORT(abort_in), .I_RECAST_PENDING(pend),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd),
        .O_REG_RDATA(rdata)
    );
    pmcr_switch_model i_sw (
        .i_clk(clk), .i_rst(rst), .i_word(sw_word), .i_type(sw_type),
        .i_avail(avail), .o_ack(ack)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // fifo: an empty queue shows a changing word so stale data cannot pass
    always @(posedge clk) begin
        if (fifo_rd && tx_valid) void'(q.pop_front());
        tx_valid <= q.size() != 0;
        if (q.size() != 0) {tx_type, tx_word} <= q[0];
        else tx_word <= ~tx_word;
    end
    always @(posedge clk) begin
        cyc++;
        if (ack === 1'b1 && t_ack < 0) t_ack = cyc;
        if (sw_type === TYP_REQ) begin
            if (sw_word[AOA_BIT] === 1'b0) naoa0++;
            else if (sw_word[BRK_BIT] === 1'b0 && naoa0 == 0) nrun++;
            if (cur_mode == MODE_CAMP && !sw_word[BRK_BIT] && t_req >= 0
                && cyc - t_req != cur_ct + 1) gap_bad++;
            t_req = sw_word[BRK_BIT] ? -1 : cyc;
        end
        if (sw_type === TYP_HDR && t_hdr < 0) begin
            t_hdr = cyc;
            hdr_idle = sw_type_prev === TYP_IDLE;
        end
        if (sw_type === TYP_DATA) ndat++;
        sw_type_prev = sw_type;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // one packet: request, pre data words, header, two data; switch grants late when pre is 0
    task automatic run_pkt(input logic [1:0] mode, input logic [2:0] ct, input logic en,
                           input logic [24:0] grant, input int pre);
        int n;
        cur_mode = mode;
        cur_ct = ct;
        t_ack = -1;
        t_hdr = -1;
        t_req = -1;
        nrun = 0;
        naoa0 = 0;
        ndat = 0;
        dly_en <= en;
        avail <= (pre != 0) ? grant : 25'h0;
        @(negedge clk);
        q.push_back({TYP_REQ, mode, 2'h0, ct, 25'h3});
        repeat (pre) q.push_back({TYP_DATA, 32'h0000_0E00});
        q.push_back({TYP_HDR, 32'h0000_0A5A});
        q.push_back({TYP_DATA, 32'h0000_0D00});
        q.push_back({TYP_DATA, 32'h0000_0D01});
        repeat (24) @(posedge clk);
        avail <= grant;
        n = 0;
        while (ndat < pre + 2 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            err_total++;
            test_done();
        end
        check("data words", ndat, pre + 2);
        check("mark", mark, 1'b1);
    endtask

    initial begin
        {rst, tx_valid, rd, wr, dly_en, abort_in, pend, hdr_idle} = 8'h80;
        {tx_type, addr, tx_word, wdata, avail, sw_type_prev} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reg_rd(REG_CFG, v);
        check("cfg reset", v, 32'h0000_00E6);
        reg_wr(REG_CFG, 32'h0000_00E3);
        reg_wr(2'h3, 32'hFFFF_FFFF);
        reg_rd(REG_CFG, v);
        check("cfg written", v, 32'h0000_00E3);
        reg_rd(2'h2, v);
        check("unmapped read", v, 32'h0000_0000);
        for (int c = 0; c < 8; c++) begin
            run_pkt(MODE_CAMP, c[2:0], c[0], 25'h3, 0);
            lat = t_hdr - t_ack;
            if (c == 0) lat0 = lat;
            check("ack to header", lat, lat0 + (c[0] ? 3 : 0));
            check("idle gap", gap_bad, 0);
        end
        for (int c = 0; c < 8; c++) begin
            run_pkt(MODE_RECAST, c[2:0], 1'b0, 25'h1, 0);
            check("recast requests", nrun, c == 0 ? 1 : 4 << c);
            check("any-grant request", naoa0 != 0, 1'b1);
        end
        reg_wr(REG_CFG, 32'h0000_02E3);
        run_pkt(MODE_CAMP, 3'h0, 1'b0, 25'h3, 10);
        check("idle before header", hdr_idle, 1'b1);
        // far side times the mark on a request that never wins, then aborts
        avail <= 25'h0;
        ndat = 0;
        @(negedge clk);
        q.push_back({TYP_REQ, MODE_CAMP, 2'h0, 3'h0, 25'h3});
        q.push_back({TYP_HDR, 32'h0000_0A5A});
        q.push_back({TYP_DATA, 32'h0000_0D00});
        repeat (30) @(posedge clk);
        check("mark while camping", mark, 1'b1);
        abort_in <= 1'b1;
        repeat (12) @(posedge clk);
        abort_in <= 1'b0;
        repeat (4) @(posedge clk);
        check("mark after abort", mark, 1'b0);
        check("aborted data words", ndat, 0);
        check("aborted words drained", q.size(), 0);
        test_done();
    end
endmodule // tb_top
